// ===== rtl/usbb_core.sv
// endpoint buffering: banks, packet sizing, completion queue, flags
// assumes one clock; i_line_nonidle is a raw line level
//
// What this block does
// - ping-pong: enabled direction is bank 0, opposite is bank 1.
// - ping-pong bank select flips after each transaction.
// - done, underrun, overrun, crc flags go to the banked direction.
// - toggle, not-ack and bank flags only in the enabled direction.
// - in token sends counter minus aux, capped at max size.
// - exact multiple with auto zero length ends in a zero length packet.
// - full in packet adds max size to aux; toggle unless isochronous.
// - short in packet adds payload, toggles unless isochronous, sets not-ack, irq and done.
// - full out packet adds max size; reaching the total completes.
// - short or oversized out packet adds payload and completes.
// - four queue bytes per endpoint at and below table pointer, while enabled.
// - five-bit negative pointers; entry count is their difference.
// - transfer irq flag set while pointers differ or queue full.
// - completion stores table address at pointer plus twice write pointer.
// - reading read pointer decrements it; reading write pointer does not.
// - ten sources on two vectors, gated by enables and nonzero level.
// - transfer vector from transfer and setup flags; endpoint registered.
// - bus vector from frame, idle, wake, reset, crc, under, over, stall.
// - wake detection runs without the clock.
// - one-cycle events: setup, frame start, crc, under or overrun.
// - writing either queue pointer empties the queue.
// - queue enable turns storage on; clearing frees the queue.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module usbb_core #(
  parameter int IDLE_CYCLES = usbb_pkg::SUSPEND_IDLE_CYC
) (
  // clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  // software register port
  input  wire logic [3:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic [7:0]               o_reg_rdata_r,
  // in token sizing
  input  wire logic                i_in_tok_valid,
  input  wire usbb_pkg::usbb_ctx_type i_in_tok_ctx,
  output logic                     o_in_len_valid_r,
  output logic [15:0]              o_in_len_r,
  output logic                     o_in_zlp_r,
  // transaction events and table write-back
  input  wire logic                i_evt_valid,
  input  wire usbb_pkg::usbb_evt_type i_evt,
  output logic                     o_wb_valid_r,
  output usbb_pkg::usbb_wb_type    o_wb_r,
  // line conditions
  input  wire logic                i_sof,
  input  wire logic                i_bus_reset,
  input  wire logic                i_line_idle,
  input  wire logic                i_line_nonidle,
  // queue store to sram
  output logic                     o_mem_we_r,
  output logic [15:0]              o_mem_addr_r,
  output logic [15:0]              o_mem_wdata_r,
  // interrupts and events
  output logic                     o_irq_xfer_r,
  output logic                     o_irq_bus_r,
  output logic                     o_evt_setup_r,
  output logic                     o_evt_sof_r,
  output logic                     o_evt_crc_r,
  output logic                     o_evt_unf_ovf_r,
  output logic                     o_wake_async_r
);

  localparam int CW = $clog2(IDLE_CYCLES + 1);

  if (IDLE_CYCLES < 1) begin : g_chk
    $error("IDLE_CYCLES must be at least one");
  end

  // next pointer with wrap at the queue size
  function automatic logic [4:0] ptr_dec(input logic [4:0] p, input logic [3:0] highest_endpoint_number);
    logic [5:0] ent;
    logic [4:0] n;
    ent = 6'((({2'b00, highest_endpoint_number} + 6'h01) * 6'(usbb_pkg::Q_BYTES_PER_EP))
             / 6'(usbb_pkg::Q_ENTRY_BYTES));
    n = p - 5'h01;
    ptr_dec = (n == 5'(6'h20 - ent)) ? 5'h00 : n;
  endfunction

  // registers
  logic [7:0]  ctrl_r, irq_en_r, flag_a_r, flag_a_nxt;
  logic [15:0] tab_ptr_r;
  logic [4:0]  wptr_r, rptr_r, wptr_nxt, rptr_nxt, last_ep_r;
  logic [3:0]  irq_lvl_r, highest_endpoint_number;
  logic [1:0]  flag_b_r, flag_b_nxt;
  logic        q_en, wr_a, wr_b, flush, rd_rptr, q_full, q_store;
  assign q_en    = ctrl_r[usbb_pkg::CTRL_QEN_BIT];
  assign highest_endpoint_number   = ctrl_r[usbb_pkg::CTRL_HIGHEST_ENDPOINT_NUMBER_LSB +: 4];
  assign wr_a    = i_reg_wr && (i_reg_addr == usbb_pkg::REG_FLAG_A);
  assign wr_b    = i_reg_wr && (i_reg_addr == usbb_pkg::REG_FLAG_B);
  assign flush   = i_reg_wr && ((i_reg_addr == usbb_pkg::REG_WPTR) ||
                                (i_reg_addr == usbb_pkg::REG_RPTR));
  assign rd_rptr = i_reg_rd && (i_reg_addr == usbb_pkg::REG_RPTR);

  // in token sizing
  usbb_pkg::usbb_ctx_type tc;
  logic        tbk;
  logic [15:0] trem, tsz;
  assign tc   = i_in_tok_ctx;
  assign tbk  = tc.ping_pong & tc.bank;
  assign tsz  = {6'h00, tc.max_size};
  assign trem = tbk ? (tc.byte_counter1 - tc.aux_byte_total1)
                    : (tc.byte_counter0 - tc.aux_byte_total0);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {o_in_len_valid_r, o_in_len_r, o_in_zlp_r} <= '0;
    end else begin
      o_in_len_valid_r <= i_in_tok_valid;
      if (i_in_tok_valid) begin
        // remaining zero after an exact multiple gives the closing empty packet
        o_in_len_r <= (!tc.multi) ? (tbk ? tc.byte_counter1 : tc.byte_counter0)
                    : ((trem < tsz) ? trem : tsz);
        o_in_zlp_r <= tc.multi && (trem == 16'h0000);
      end
    end
  end

  // completion arithmetic
  usbb_pkg::usbb_ctx_type c;
  usbb_pkg::usbb_wb_type  wb_nxt;
  logic        bk, done_ok, full_pkt;
  logic [15:0] sel_cnt, sel_aux, sz, cnt_sum;
  assign c        = i_evt.ctx;
  assign bk       = c.ping_pong & c.bank;
  assign sel_cnt  = bk ? c.byte_counter1 : c.byte_counter0;
  assign sel_aux  = bk ? c.aux_byte_total1 : c.aux_byte_total0;
  assign sz       = {6'h00, c.max_size};
  assign full_pkt = (i_evt.payload == sz);
  assign cnt_sum  = sel_cnt + i_evt.payload;
  always_comb begin
    wb_nxt                = '0;
    done_ok               = 1'b0;
    wb_nxt.byte_counter   = sel_cnt;
    wb_nxt.aux_byte_total = sel_aux;
    wb_nxt.data_bank      = bk;
    wb_nxt.stat_dir       = bk;
    wb_nxt.toggle         = c.toggle;
    wb_nxt.bank           = c.bank;
    unique case (i_evt.kind)
      usbb_pkg::EV_IN_DONE: begin
        wb_nxt.toggle = c.iso ? c.toggle : ~c.toggle;
        wb_nxt.bank   = c.ping_pong ? ~c.bank : c.bank;
        if (c.multi) begin
          // full packet payload equals max size, so one add serves both cases
          wb_nxt.aux_byte_total = sel_aux + i_evt.payload;
          done_ok = !full_pkt ||
                    (!c.auto_zero_len_enable && ((sel_cnt - sel_aux) == sz));
        end else begin
          done_ok = 1'b1;
        end
      end
      usbb_pkg::EV_OUT_DONE: begin
        wb_nxt.toggle = c.iso ? c.toggle : ~c.toggle;
        wb_nxt.bank   = c.ping_pong ? ~c.bank : c.bank;
        if (c.multi) begin
          wb_nxt.byte_counter = cnt_sum;
          done_ok = !full_pkt || (cnt_sum == sel_aux);
        end else begin
          wb_nxt.byte_counter = i_evt.payload;
          done_ok = 1'b1;
        end
      end
      usbb_pkg::EV_UNDERRUN:   wb_nxt.underrun_flag = 1'b1;
      usbb_pkg::EV_OVERRUN:    wb_nxt.overrun_flag  = 1'b1;
      usbb_pkg::EV_CRC_ERR:    wb_nxt.crc_flag      = 1'b1;
      default:                 ;
    endcase
    if (done_ok) begin
      wb_nxt.done_set        = 1'b1;
      // not-ack bits live in the enabled direction, bank picks which one
      wb_nxt.buffer0_not_ack = ~bk;
      wb_nxt.buffer1_not_ack = bk;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {o_wb_valid_r, o_wb_r} <= '0;
    end else begin
      o_wb_valid_r <= i_evt_valid;
      if (i_evt_valid) begin
        o_wb_r <= wb_nxt;
      end
    end
  end

  // completion queue
  logic trn_set, setup_set;
  assign trn_set   = i_evt_valid && done_ok;
  assign setup_set = i_evt_valid && (i_evt.kind == usbb_pkg::EV_SETUP_DONE);
  assign q_full    = (ptr_dec(wptr_r, highest_endpoint_number) == rptr_r);
  // a full queue drops the entry rather than overwrite the oldest
  assign q_store   = q_en && trn_set && !q_full;
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (q_store) begin
      wptr_nxt = ptr_dec(wptr_r, highest_endpoint_number);
    end
    if (rd_rptr) begin
      rptr_nxt = ptr_dec(rptr_r, highest_endpoint_number);
    end
    if (flush || !q_en) begin
      wptr_nxt = usbb_pkg::RST_PTR;
      rptr_nxt = usbb_pkg::RST_PTR;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {wptr_r, rptr_r} <= {2{usbb_pkg::RST_PTR}};
    end else begin
      {wptr_r, rptr_r} <= {wptr_nxt, rptr_nxt};
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {o_mem_we_r, o_mem_addr_r, o_mem_wdata_r} <= '0;
    end else begin
      o_mem_we_r <= q_store;
      if (q_store) begin
        // negative pointer sign-extended, entries grow downward
        o_mem_addr_r  <= tab_ptr_r + {{10{wptr_r[4]}}, wptr_r, 1'b0};
        o_mem_wdata_r <= i_evt.tab_addr;
      end
    end
  end

  // suspend detection and clockless wake
  logic [CW-1:0] idle_cnt_r;
  logic          suspended_r, idle_hit, wake_clr_r, wake_seen;
  logic          wake_async_s1_r, wake_async_s2_r, wake_async_s3_r;
  assign idle_hit  = i_line_idle && !suspended_r && (idle_cnt_r == CW'(IDLE_CYCLES - 1));
  assign wake_seen = wake_async_s2_r && !wake_async_s3_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {idle_cnt_r, suspended_r} <= '0;
    end else begin
      if (!i_line_idle || suspended_r) begin
        idle_cnt_r <= '0;
      end else begin
        idle_cnt_r <= idle_cnt_r + CW'(1);
      end
      if (idle_hit) begin
        suspended_r <= 1'b1;
      end else if (wake_seen || i_bus_reset) begin
        suspended_r <= 1'b0;
      end
    end
  end

  // armed only while suspended; the line edge itself clocks the catch flop
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wake_clr_r <= 1'b1;
    end else begin
      wake_clr_r <= !suspended_r;
    end
  end

  always_ff @(posedge i_line_nonidle or posedge wake_clr_r) begin
    if (wake_clr_r) begin
      o_wake_async_r <= 1'b0;
    end else begin
      o_wake_async_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {wake_async_s3_r, wake_async_s2_r, wake_async_s1_r} <= 3'b000;
    end else begin
      {wake_async_s3_r, wake_async_s2_r, wake_async_s1_r} <=
        {wake_async_s2_r, wake_async_s1_r, o_wake_async_r};
    end
  end

  // interrupt flags, set wins over software clear
  always_comb begin
    flag_a_nxt = flag_a_r;
    if (wr_a) begin
      flag_a_nxt = flag_a_r & ~i_reg_wdata;
    end
    flag_a_nxt[usbb_pkg::FA_SOF]  = flag_a_nxt[usbb_pkg::FA_SOF] | i_sof;
    flag_a_nxt[usbb_pkg::FA_IDLE] = flag_a_nxt[usbb_pkg::FA_IDLE] | idle_hit;
    flag_a_nxt[usbb_pkg::FA_WAKE] = flag_a_nxt[usbb_pkg::FA_WAKE] | wake_seen;
    flag_a_nxt[usbb_pkg::FA_RST]  = flag_a_nxt[usbb_pkg::FA_RST] | i_bus_reset;
    if (i_evt_valid) begin
      flag_a_nxt[usbb_pkg::FA_CRC]   = flag_a_nxt[usbb_pkg::FA_CRC] | wb_nxt.crc_flag;
      flag_a_nxt[usbb_pkg::FA_UNF]   = flag_a_nxt[usbb_pkg::FA_UNF] | wb_nxt.underrun_flag;
      flag_a_nxt[usbb_pkg::FA_OVF]   = flag_a_nxt[usbb_pkg::FA_OVF] | wb_nxt.overrun_flag;
      flag_a_nxt[usbb_pkg::FA_STALL] = flag_a_nxt[usbb_pkg::FA_STALL] |
                                       (i_evt.kind == usbb_pkg::EV_STALL);
    end
  end

  always_comb begin
    flag_b_nxt = flag_b_r;
    if (wr_b) begin
      flag_b_nxt = flag_b_r & ~i_reg_wdata[1:0];
    end
    flag_b_nxt[usbb_pkg::FB_SETUP] = flag_b_nxt[usbb_pkg::FB_SETUP] | setup_set;
    if (q_en) begin
      // with the queue on the flag mirrors the queue, not the write
      flag_b_nxt[usbb_pkg::FB_XFER] = (rptr_nxt != wptr_nxt) ||
                                      (trn_set && q_full);
    end else begin
      flag_b_nxt[usbb_pkg::FB_XFER] = flag_b_nxt[usbb_pkg::FB_XFER] | trn_set;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {flag_a_r, flag_b_r, last_ep_r} <= '0;
    end else begin
      flag_a_r <= flag_a_nxt;
      flag_b_r <= flag_b_nxt;
      if (trn_set || setup_set) begin
        last_ep_r <= {i_evt.dir, i_evt.ep_num};
      end
    end
  end

  // interrupt requests and events
  logic [7:0] bus_mask;
  assign bus_mask = {irq_en_r[usbb_pkg::EN_STALL], {3{irq_en_r[usbb_pkg::EN_BUSERR]}},
                     {3{irq_en_r[usbb_pkg::EN_BUSEV]}}, irq_en_r[usbb_pkg::EN_SOF]};
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {o_irq_xfer_r, o_irq_bus_r} <= 2'b00;
      {o_evt_setup_r, o_evt_sof_r, o_evt_crc_r, o_evt_unf_ovf_r} <= 4'h0;
    end else begin
      o_irq_xfer_r <= (irq_lvl_r[usbb_pkg::LVL_XFER_LSB +: 2] != 2'b00) &&
                      ((flag_b_r[usbb_pkg::FB_XFER] && irq_en_r[usbb_pkg::EN_XFER]) ||
                       (flag_b_r[usbb_pkg::FB_SETUP] && irq_en_r[usbb_pkg::EN_SETUP]));
      o_irq_bus_r <= (irq_lvl_r[usbb_pkg::LVL_BUS_LSB +: 2] != 2'b00) &&
                     ((flag_a_r & bus_mask) != 8'h00);
      o_evt_setup_r   <= setup_set;
      o_evt_sof_r     <= i_sof;
      o_evt_crc_r     <= i_evt_valid && wb_nxt.crc_flag;
      o_evt_unf_ovf_r <= i_evt_valid && (wb_nxt.underrun_flag || wb_nxt.overrun_flag);
    end
  end

  // software writes
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_r    <= usbb_pkg::RST_CTRL;
      tab_ptr_r <= usbb_pkg::RST_TAB;
      irq_en_r  <= usbb_pkg::RST_IRQ_EN;
      irq_lvl_r <= usbb_pkg::RST_LVL;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        usbb_pkg::REG_CTRL:    ctrl_r <= {3'b000, i_reg_wdata[4:0]};
        usbb_pkg::REG_TAB_LO:  tab_ptr_r[7:0] <= {i_reg_wdata[7:1], 1'b0};
        usbb_pkg::REG_TAB_HI:  tab_ptr_r[15:8] <= i_reg_wdata;
        usbb_pkg::REG_IRQ_EN:  irq_en_r <= {2'b00, i_reg_wdata[5:0]};
        usbb_pkg::REG_IRQ_LVL: irq_lvl_r <= i_reg_wdata[3:0];
        default:               ;
      endcase
    end
  end

  // software reads, data stand the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata_r <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        usbb_pkg::REG_CTRL:    o_reg_rdata_r <= ctrl_r;
        usbb_pkg::REG_TAB_LO:  o_reg_rdata_r <= tab_ptr_r[7:0];
        usbb_pkg::REG_TAB_HI:  o_reg_rdata_r <= tab_ptr_r[15:8];
        usbb_pkg::REG_WPTR:    o_reg_rdata_r <= {3'b000, wptr_r};
        usbb_pkg::REG_RPTR:    o_reg_rdata_r <= {3'b000, rptr_r};
        usbb_pkg::REG_IRQ_EN:  o_reg_rdata_r <= irq_en_r;
        usbb_pkg::REG_IRQ_LVL: o_reg_rdata_r <= {4'h0, irq_lvl_r};
        usbb_pkg::REG_FLAG_A:  o_reg_rdata_r <= flag_a_r;
        usbb_pkg::REG_FLAG_B:  o_reg_rdata_r <= {6'h00, flag_b_r};
        usbb_pkg::REG_LAST_EP: o_reg_rdata_r <= {3'b000, last_ep_r};
        default:               o_reg_rdata_r <= 8'h00;
      endcase
    end
  end

endmodule

// ===== rtl/usbb_pkg.sv
// constants and carrier types of the endpoint buffering block
// assumes one 250 mhz clock
package usbb_pkg;

  // clock and suspend timing
  localparam int CLK_MHZ           = 250;
  localparam int SUSPEND_IDLE_MS   = 3;
  localparam int SUSPEND_IDLE_CYC  = SUSPEND_IDLE_MS * 1000 * CLK_MHZ;

  // register offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_TAB_LO  = 4'h1;
  localparam logic [3:0] REG_TAB_HI  = 4'h2;
  localparam logic [3:0] REG_WPTR    = 4'h3;
  localparam logic [3:0] REG_RPTR    = 4'h4;
  localparam logic [3:0] REG_IRQ_EN  = 4'h5;
  localparam logic [3:0] REG_IRQ_LVL = 4'h6;
  localparam logic [3:0] REG_FLAG_A  = 4'h7;
  localparam logic [3:0] REG_FLAG_B  = 4'h8;
  localparam logic [3:0] REG_LAST_EP = 4'h9;

  // ctrl fields
  localparam int CTRL_QEN_BIT   = 4;
  localparam int CTRL_HIGHEST_ENDPOINT_NUMBER_LSB = 0;

  // irq enable fields
  localparam int EN_SOF    = 0;
  localparam int EN_BUSEV  = 1;
  localparam int EN_BUSERR = 2;
  localparam int EN_STALL  = 3;
  localparam int EN_XFER   = 4;
  localparam int EN_SETUP  = 5;

  // irq level fields
  localparam int LVL_XFER_LSB = 0;
  localparam int LVL_BUS_LSB  = 2;

  // flag a bits, bus event vector
  localparam int FA_SOF   = 0;
  localparam int FA_IDLE  = 1;
  localparam int FA_WAKE  = 2;
  localparam int FA_RST   = 3;
  localparam int FA_CRC   = 4;
  localparam int FA_UNF   = 5;
  localparam int FA_OVF   = 6;
  localparam int FA_STALL = 7;

  // flag b bits, transaction complete vector
  localparam int FB_XFER  = 0;
  localparam int FB_SETUP = 1;

  // queue geometry: bytes per endpoint and two-byte entries
  localparam int Q_BYTES_PER_EP = 4;
  localparam int Q_ENTRY_BYTES  = 2;

  // reset values
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_TAB    = 16'h0000;
  localparam logic [4:0]  RST_PTR    = 5'h00;
  localparam logic [7:0]  RST_IRQ_EN = 8'h00;
  localparam logic [3:0]  RST_LVL    = 4'h0;

  // completion and error events from the token logic
  typedef enum logic [2:0] {
    EV_IN_DONE    = 3'h0,
    EV_OUT_DONE   = 3'h1,
    EV_SETUP_DONE = 3'h2,
    EV_UNDERRUN   = 3'h3,
    EV_OVERRUN    = 3'h4,
    EV_CRC_ERR    = 3'h5,
    EV_STALL      = 3'h6
  } usbb_evt_kind_type;

  // endpoint context as fetched from the table
  typedef struct packed {
    logic        iso;
    logic        ping_pong;
    logic        multi;
    logic        auto_zero_len_enable;
    logic        bank;
    logic        toggle;
    logic [9:0]  max_size;
    logic [15:0] byte_counter0;
    logic [15:0] aux_byte_total0;
    logic [15:0] byte_counter1;
    logic [15:0] aux_byte_total1;
  } usbb_ctx_type;

  typedef struct packed {
    usbb_evt_kind_type kind;
    usbb_ctx_type      ctx;
    logic [15:0]       payload;
    logic [3:0]        ep_num;
    logic              dir;
    logic [15:0]       tab_addr;
  } usbb_evt_type;

  // write-back to the endpoint table
  typedef struct packed {
    logic [15:0] byte_counter;
    logic [15:0] aux_byte_total;
    logic        data_bank;
    logic        stat_dir;
    logic        done_set;
    logic        underrun_flag;
    logic        overrun_flag;
    logic        crc_flag;
    logic        buffer0_not_ack;
    logic        buffer1_not_ack;
    logic        toggle;
    logic        bank;
  } usbb_wb_type;

endpackage

// ===== test/usbb_core_properties.sv
// timing checks on the buffering block ports
// assumes a bind onto usbb_core, one clock domain
`timescale 1ns/1ps
module usbb_core_properties (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic                   i_in_tok_valid,
  input wire logic                   i_evt_valid,
  input wire usbb_pkg::usbb_evt_type i_evt,
  input wire logic                   i_sof,
  input wire logic                   o_in_len_valid_r,
  input wire logic                   o_wb_valid_r,
  input wire logic                   o_mem_we_r,
  input wire logic                   o_evt_setup_r,
  input wire logic                   o_evt_sof_r,
  input wire logic                   o_evt_crc_r,
  input wire logic                   o_evt_unf_ovf_r
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic               ev_done;
  usbb_pkg::usbb_evt_kind_type k;
  assign k = i_evt.kind;
  assign ev_done = i_evt_valid && (k == usbb_pkg::EV_IN_DONE || k == usbb_pkg::EV_OUT_DONE);
  AST_IN_ANSWER: assert property (i_in_tok_valid |=> o_in_len_valid_r)
    else $error("in length not answered");
  AST_IN_CAUSE: assert property (o_in_len_valid_r |-> $past(i_in_tok_valid))
    else $error("in length without token");
  AST_WB_ANSWER: assert property (i_evt_valid |=> o_wb_valid_r)
    else $error("write-back missing");
  AST_STORE_CAUSE: assert property (o_mem_we_r |-> $past(ev_done))
    else $error("queue store without completion");
  AST_SETUP_EVT: assert property (i_evt_valid && k == usbb_pkg::EV_SETUP_DONE
    |=> o_evt_setup_r)
    else $error("setup event missing");
  AST_CRC_EVT: assert property (i_evt_valid && k == usbb_pkg::EV_CRC_ERR |=> o_evt_crc_r)
    else $error("crc event missing");
  AST_UO_EVT: assert property (i_evt_valid && (k == usbb_pkg::EV_UNDERRUN
    || k == usbb_pkg::EV_OVERRUN) |=> o_evt_unf_ovf_r)
    else $error("under or overrun event missing");
  AST_SOF_PULSE: assert property (i_sof && !$past(i_sof) |=> o_evt_sof_r ##1 !o_evt_sof_r)
    else $error("frame event not one cycle");
endmodule

// ===== test/usbb_host_model.sv
// token and line side model facing the buffering block
// assumes the bench calls its tasks; one clock
`timescale 1ns/1ps
module usbb_host_model (
  input  wire logic        i_clk_sys,
  output logic             o_tok_valid,
  output usbb_pkg::usbb_ctx_type o_tok_ctx,
  output logic             o_evt_valid,
  output usbb_pkg::usbb_evt_type o_evt,
  output logic             o_sof,
  output logic             o_idle,
  output logic             o_nonidle
);
  initial begin
    {o_tok_valid, o_evt_valid, o_sof, o_idle, o_nonidle} = '0;
    o_tok_ctx = '0;
    o_evt = '0;
  end
  // contexts come from the bench: ping-pong only on bulk, counts preset
  task automatic tok(input usbb_pkg::usbb_ctx_type c);
    @(posedge i_clk_sys);
    o_tok_valid <= 1'b1;
    o_tok_ctx <= c;
    @(posedge i_clk_sys);
    o_tok_valid <= 1'b0;
    o_tok_ctx <= ~c; // released context is garbage
  endtask
  task automatic evt(input usbb_pkg::usbb_evt_type e);
    @(posedge i_clk_sys);
    o_evt_valid <= 1'b1;
    o_evt <= e;
    @(posedge i_clk_sys);
    o_evt_valid <= 1'b0;
    o_evt <= ~e;
  endtask
  task automatic sof();
    @(posedge i_clk_sys);
    o_sof <= 1'b1;
    @(posedge i_clk_sys);
    o_sof <= 1'b0;
  endtask
  // idle span, then traffic resumes on the raw line
  task automatic idle(input int n);
    @(posedge i_clk_sys);
    o_idle <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    o_idle <= 1'b0;
    o_nonidle <= 1'b1;
  endtask
endmodule

// ===== test/usbb_core_test.sv
// bench for the buffering block: sizing, write-back, queue, flags, events
// assumes the host model drives token and line inputs
`timescale 1ns/1ps
module usbb_core_test;
  logic        i_clk_sys, i_rst, i_reg_wr, i_reg_rd, i_bus_reset;
  logic        i_in_tok_valid, i_evt_valid, i_sof, i_line_idle, i_line_nonidle;
  logic        o_in_len_valid_r, o_in_zlp_r, o_wb_valid_r, o_mem_we_r;
  logic        o_irq_xfer_r, o_irq_bus_r, o_evt_setup_r, o_evt_sof_r;
  logic        o_evt_crc_r, o_evt_unf_ovf_r, o_wake_async_r;
  logic [3:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata_r;
  logic [15:0] o_in_len_r, o_mem_addr_r, o_mem_wdata_r;
  usbb_pkg::usbb_ctx_type i_in_tok_ctx;
  usbb_pkg::usbb_evt_type i_evt;
  usbb_pkg::usbb_wb_type  o_wb_r;
  int          fails, check_count;
  usbb_core #(.IDLE_CYCLES(20)) u_usbb_core (.i_clk_sys, .i_rst, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata_r, .i_in_tok_valid, .i_in_tok_ctx, .o_in_len_valid_r,
    .o_in_len_r, .o_in_zlp_r, .i_evt_valid, .i_evt, .o_wb_valid_r, .o_wb_r, .i_sof,
    .i_bus_reset, .i_line_idle, .i_line_nonidle, .o_mem_we_r, .o_mem_addr_r, .o_mem_wdata_r,
    .o_irq_xfer_r, .o_irq_bus_r, .o_evt_setup_r, .o_evt_sof_r, .o_evt_crc_r,
    .o_evt_unf_ovf_r, .o_wake_async_r);
  usbb_host_model u_usbb_host_model (.i_clk_sys, .o_tok_valid(i_in_tok_valid),
    .o_tok_ctx(i_in_tok_ctx), .o_evt_valid(i_evt_valid), .o_evt(i_evt), .o_sof(i_sof),
    .o_idle(i_line_idle), .o_nonidle(i_line_nonidle));
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata_r, e);
  endtask
  function automatic usbb_pkg::usbb_ctx_type mk(input logic pp, b, z, iso,
      input logic [15:0] c0, a0, c1, a1);
    mk = '{iso, pp, 1'b1, z, b, 1'b0, 10'h040, c0, a0, c1, a1};
  endfunction
  task automatic ev(input usbb_pkg::usbb_evt_kind_type k, input usbb_pkg::usbb_ctx_type c,
      input logic [15:0] p, input logic [15:0] t);
    u_usbb_host_model.evt('{k, c, p, 4'h1, 1'b0, t});
    #1 chk(o_wb_valid_r, 1);
  endtask
  task automatic tok(input usbb_pkg::usbb_ctx_type c, input logic [15:0] n, input logic z);
    u_usbb_host_model.tok(c);
    #1 chk({o_in_len_valid_r, o_in_zlp_r, o_in_len_r}, {1'b1, z, n});
  endtask
  task automatic t_reset();
    rd(usbb_pkg::REG_CTRL, 8'h00);
    rd(usbb_pkg::REG_WPTR, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
  endtask
  task automatic t_in_size();
    tok(mk(0, 0, 0, 0, 100, 64, 0, 0), 36, 0);
    tok(mk(0, 0, 0, 0, 200, 64, 0, 0), 64, 0);
    tok(mk(0, 0, 1, 0, 128, 128, 0, 0), 0, 1);
    tok(mk(1, 1, 0, 0, 200, 0, 90, 64), 26, 0);
  endtask
  task automatic t_wb();
    ev(usbb_pkg::EV_OUT_DONE, mk(0, 0, 0, 0, 64, 128, 0, 0), 64, 0);
    chk({o_wb_r.byte_counter, o_wb_r.done_set, o_wb_r.buffer0_not_ack, o_wb_r.toggle},
      {16'd128, 3'b111});
    ev(usbb_pkg::EV_OUT_DONE, mk(0, 0, 0, 1, 0, 128, 0, 0), 20, 0);
    chk({o_wb_r.byte_counter, o_wb_r.done_set, o_wb_r.toggle}, {16'd20, 2'b10});
    ev(usbb_pkg::EV_IN_DONE, mk(0, 0, 0, 0, 100, 64, 0, 0), 36, 0);
    chk({o_wb_r.aux_byte_total, o_wb_r.done_set, o_wb_r.toggle}, {16'd100, 2'b11});
    ev(usbb_pkg::EV_OUT_DONE, mk(1, 1, 0, 0, 0, 64, 0, 64), 64, 0);
    chk({o_wb_r.stat_dir, o_wb_r.bank}, 2'b10);
  endtask
  task automatic t_queue();
    wr(usbb_pkg::REG_CTRL, 8'h13);
    wr(usbb_pkg::REG_TAB_HI, 8'h01);
    wr(usbb_pkg::REG_IRQ_EN, 8'h10);
    wr(usbb_pkg::REG_IRQ_LVL, 8'h01);
    ev(usbb_pkg::EV_OUT_DONE, mk(0, 0, 0, 0, 0, 64, 0, 0), 64, 16'h0108);
    chk({o_mem_we_r, o_mem_addr_r, o_mem_wdata_r}, {1'b1, 32'h01000108});
    rd(usbb_pkg::REG_WPTR, 8'h1f);
    rd(usbb_pkg::REG_WPTR, 8'h1f);
    rd(usbb_pkg::REG_FLAG_B, 8'h01);
    chk(o_irq_xfer_r, 1);
    ev(usbb_pkg::EV_IN_DONE, mk(0, 0, 0, 0, 10, 0, 0, 0), 10, 16'h0110);
    chk(o_mem_addr_r, 16'h00fe);
    rd(usbb_pkg::REG_RPTR, 8'h00);
    rd(usbb_pkg::REG_RPTR, 8'h1f);
    rd(usbb_pkg::REG_FLAG_B, 8'h00);
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_irq_xfer_r, 0);
    ev(usbb_pkg::EV_OUT_DONE, mk(0, 0, 0, 0, 0, 64, 0, 0), 64, 16'h0108);
    wr(usbb_pkg::REG_WPTR, 8'h00);
    rd(usbb_pkg::REG_WPTR, 8'h00);
  endtask
  task automatic t_events();
    ev(usbb_pkg::EV_SETUP_DONE, mk(0, 0, 0, 0, 0, 0, 0, 0), 8, 0);
    chk(o_evt_setup_r, 1);
    ev(usbb_pkg::EV_CRC_ERR, mk(0, 0, 0, 1, 0, 0, 0, 0), 8, 0);
    chk(o_evt_crc_r, 1);
    ev(usbb_pkg::EV_UNDERRUN, mk(0, 0, 0, 0, 0, 0, 0, 0), 0, 0);
    chk(o_evt_unf_ovf_r, 1);
    ev(usbb_pkg::EV_OVERRUN, mk(0, 0, 0, 0, 0, 0, 0, 0), 0, 0);
    ev(usbb_pkg::EV_STALL, mk(0, 0, 0, 0, 0, 0, 0, 0), 0, 0);
    wr(usbb_pkg::REG_IRQ_EN, 8'h04);
    #1 chk(o_irq_bus_r, 0);
    wr(usbb_pkg::REG_IRQ_LVL, 8'h04);
    rd(usbb_pkg::REG_FLAG_A, 8'hf0);
    chk(o_irq_bus_r, 1);
    wr(usbb_pkg::REG_FLAG_A, 8'hff);
    repeat (2) @(posedge i_clk_sys);
    #1 chk(o_irq_bus_r, 0);
    u_usbb_host_model.sof();
    #1 chk(o_evt_sof_r, 1);
    rd(usbb_pkg::REG_FLAG_A, 8'h01);
    wr(usbb_pkg::REG_FLAG_A, 8'hff);
    u_usbb_host_model.idle(25);
    #1 chk(o_wake_async_r, 1);
    repeat (6) @(posedge i_clk_sys);
    rd(usbb_pkg::REG_FLAG_A, 8'h06);
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, i_bus_reset, i_reg_addr, i_reg_wdata} = '0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_reset();
    t_in_size();
    t_wb();
    t_queue();
    t_events();
    tally_and_finish();
  end
  // run needs under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fails++;
    tally_and_finish();
  end
endmodule
bind usbb_core usbb_core_properties u_usbb_core_properties (.i_clk_sys, .i_rst,
  .i_in_tok_valid, .i_evt_valid, .i_evt, .i_sof, .o_in_len_valid_r, .o_wb_valid_r,
  .o_mem_we_r, .o_evt_setup_r, .o_evt_sof_r, .o_evt_crc_r, .o_evt_unf_ovf_r);
